// ==== pkg/gdb_pkg.sv ====
// Package: constants and types for the glyph download buffer
package gdb_pkg;
    localparam logic [15:0]        CODE_MIN     = 16'h0021;
    localparam logic [15:0]        CODE_MAX     = 16'h007E;
    localparam logic [6:0]         CODE_BASE    = 7'h21;
    localparam int                 GLYPHS       = 94;
    localparam logic signed [15:0] PEN_LIFT     = 16'shFF80;
    localparam logic signed [15:0] COORD_MIN    = 16'shFF81;
    localparam logic signed [15:0] COORD_MAX    = 16'sh007F;
    localparam logic [7:0]         LIFT_BYTE    = 8'h80;
    localparam int                 MAX_PARAMS   = 255;
    localparam logic [8:0]         MAX_PRM_CNT  = 9'h0FF;
    localparam logic [16:0]        OVERHEAD     = 17'h001C4;
    localparam logic signed [15:0] CELL_W       = 16'sh0030;
    localparam logic signed [15:0] CELL_H       = 16'sh0040;
    localparam logic [15:0]        DEF_CAP      = 16'h0400;
    localparam logic [3:0]         ERR_NONE     = 4'h0;
    localparam logic [3:0]         ERR_COUNT    = 4'h2;
    localparam logic [3:0]         ERR_RANGE    = 4'h3;
    localparam logic [3:0]         ERR_OVERFLOW = 4'h7;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_PARSE = 3'b010,
        ST_DRAW  = 3'b100
    } gdb_state_t;
endpackage

// ==== src/gdb_glyph_buffer.sv ====
// Glyph download buffer: define-glyph command interpreter, store and playback
`timescale 1ns/100ps
module gdb_glyph_buffer #(
    parameter int SLOT_BYTES  = 32,
    parameter int STAGE_DEPTH = 255
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic               cmd_start,
    input  wire logic               prm_valid,
    input  wire logic signed [15:0] prm_value,
    input  wire logic               cmd_end,
    input  wire logic               init_evt,
    input  wire logic               dflt_evt,
    input  wire logic               alloc_evt,
    input  wire logic [15:0]        alloc_bytes,
    input  wire logic               fb_sel_valid,
    input  wire logic [1:0]         fb_sel_mode,
    input  wire logic               draw_req,
    input  wire logic [7:0]         draw_code,
    input  wire logic signed [15:0] draw_ox,
    input  wire logic signed [15:0] draw_oy,
    output logic                    busy,
    output logic                    cmd_done,
    output logic                    err_valid,
    output logic [3:0]              err_code,
    output logic                    mv_valid,
    output logic signed [15:0]      mv_x,
    output logic signed [15:0]      mv_y,
    output logic                    mv_pen_down,
    output logic                    adv_valid,
    output logic signed [15:0]      adv_x,
    output logic signed [15:0]      adv_y,
    output logic                    miss_valid,
    output logic [1:0]              miss_mode,
    output logic [15:0]             used_bytes
);
    typedef struct packed {
        gdb_pkg::gdb_state_t                      st;
        logic [STAGE_DEPTH-1:0][7:0]              stage;
        logic [8:0]                               n_prm;
        logic                                     have_code;
        logic [6:0]                               code;
        logic                                     bad;
        logic                                     trunc;
        logic                                     lift_pend;
        logic                                     odd;
        logic [gdb_pkg::GLYPHS-1:0][SLOT_BYTES-1:0][7:0] slot;
        logic [gdb_pkg::GLYPHS-1:0][8:0]          len;
        logic [15:0]                              used;
        logic [15:0]                              cap;
        logic [1:0]                               fb_mode;
        logic [6:0]                               dcode;
        logic [8:0]                               di;
        logic                                     first;
        logic                                     lift;
        logic                                     xhave;
        logic [7:0]                               xl;
        logic signed [15:0]                       ox;
        logic signed [15:0]                       oy;
        logic                                     busy;
        logic                                     cmd_done;
        logic                                     err_valid;
        logic [3:0]                               err_code;
        logic                                     mv_valid;
        logic signed [15:0]                       mv_x;
        logic signed [15:0]                       mv_y;
        logic                                     mv_pen_down;
        logic                                     adv_valid;
        logic signed [15:0]                       adv_x;
        logic signed [15:0]                       adv_y;
        logic                                     miss_valid;
        logic [1:0]                               miss_mode;
    } gdb_reg_t;

    gdb_reg_t    s;
    gdb_reg_t    next_s;
    logic [8:0]  cur_len;
    logic [8:0]  need;
    logic [16:0] total;
    logic [6:0]  req_idx;
    logic        req_hit;
    logic [7:0]  ent;

    assign cur_len = s.len[s.code];
    assign need    = 9'(s.n_prm + 9'h001);
    assign total   = 17'(17'(s.used) - 17'(cur_len) + 17'(need) + gdb_pkg::OVERHEAD);
    assign req_idx = 7'(draw_code[6:0] - gdb_pkg::CODE_BASE);
    assign req_hit = ({8'h00, draw_code} >= gdb_pkg::CODE_MIN)
                   && ({8'h00, draw_code} <= gdb_pkg::CODE_MAX)
                   && (s.len[req_idx] != 9'h000);

    always_comb begin
        next_s = s;
        ent = s.slot[s.dcode][s.di];
        next_s.cmd_done   = 1'b0;
        next_s.err_valid  = 1'b0;
        next_s.mv_valid   = 1'b0;
        next_s.adv_valid  = 1'b0;
        next_s.miss_valid = 1'b0;

        if (fb_sel_valid) begin
            next_s.fb_mode = fb_sel_mode;
        end

        case (s.st)
            gdb_pkg::ST_IDLE: begin
                if (draw_req) begin
                    if (req_hit) begin
                        next_s.st    = gdb_pkg::ST_DRAW;
                        next_s.dcode = req_idx;
                        next_s.di    = 9'h000;
                        next_s.first = 1'b1;
                        next_s.lift  = 1'b0;
                        next_s.xhave = 1'b0;
                        next_s.ox    = draw_ox;
                        next_s.oy    = draw_oy;
                    end else begin
                        next_s.miss_valid = 1'b1;
                        next_s.miss_mode  = s.fb_mode;
                    end
                end
            end
            gdb_pkg::ST_PARSE: begin
                if (prm_valid) begin
                    if (!s.have_code) begin
                        next_s.have_code = 1'b1;
                        next_s.code = 7'(prm_value[6:0] - gdb_pkg::CODE_BASE);
                        if ($unsigned(prm_value) < gdb_pkg::CODE_MIN
                            || $unsigned(prm_value) > gdb_pkg::CODE_MAX) begin
                            next_s.bad = 1'b1;
                        end
                    end else if (s.n_prm == gdb_pkg::MAX_PRM_CNT) begin
                        next_s.trunc = 1'b1;
                    end else begin
                        next_s.n_prm = 9'(s.n_prm + 9'h001);
                        if (prm_value == gdb_pkg::PEN_LIFT) begin
                            // A lift in the Y slot or a second lift leaves a bare lift
                            if (s.odd || s.lift_pend) begin
                                next_s.bad = 1'b1;
                            end
                            next_s.lift_pend = 1'b1;
                            next_s.stage[s.n_prm] = gdb_pkg::LIFT_BYTE;
                        end else begin
                            if (prm_value < gdb_pkg::COORD_MIN
                                || prm_value > gdb_pkg::COORD_MAX) begin
                                next_s.bad = 1'b1;
                            end
                            next_s.stage[s.n_prm] = prm_value[7:0];
                            next_s.odd       = ~s.odd;
                            next_s.lift_pend = 1'b0;
                        end
                    end
                end else if (cmd_end) begin
                    next_s.st       = gdb_pkg::ST_IDLE;
                    next_s.cmd_done = 1'b1;
                    if (!s.have_code) begin
                        next_s.len  = '0;
                        next_s.used = 16'h0000;
                    end else if (s.bad) begin
                        next_s.err_valid = 1'b1;
                        next_s.err_code  = gdb_pkg::ERR_RANGE;
                    end else if (s.n_prm == 9'h000) begin
                        next_s.len[s.code] = 9'h000;
                        next_s.used = 16'(s.used - 16'(cur_len));
                    end else if (s.odd || s.lift_pend) begin
                        next_s.err_valid = 1'b1;
                        next_s.err_code  = gdb_pkg::ERR_RANGE;
                    end else if (total > 17'(s.cap) || 32'(need) > SLOT_BYTES) begin
                        // Old definition is lost too, so software sees a clean hole
                        next_s.len[s.code] = 9'h000;
                        next_s.used = 16'(s.used - 16'(cur_len));
                        next_s.err_valid = 1'b1;
                        next_s.err_code  = gdb_pkg::ERR_OVERFLOW;
                    end else begin
                        // Only now is the staged command known good
                        for (int k = 0; k < SLOT_BYTES && k < STAGE_DEPTH; k++) begin
                            next_s.slot[s.code][k] = s.stage[k];
                        end
                        next_s.len[s.code] = need;
                        next_s.used = 16'(s.used - 16'(cur_len) + 16'(need));
                        if (s.trunc) begin
                            next_s.err_valid = 1'b1;
                            next_s.err_code  = gdb_pkg::ERR_COUNT;
                        end
                    end
                end
            end
            gdb_pkg::ST_DRAW: begin
                if (s.di == 9'(s.len[s.dcode] - 9'h001)) begin
                    // Advance from the kept origin, not the last pen point
                    next_s.st        = gdb_pkg::ST_IDLE;
                    next_s.adv_valid = 1'b1;
                    next_s.adv_x     = 16'(s.ox + gdb_pkg::CELL_W);
                    next_s.adv_y     = s.oy;
                end else begin
                    next_s.di = 9'(s.di + 9'h001);
                    if (ent == gdb_pkg::LIFT_BYTE) begin
                        next_s.lift = 1'b1;
                    end else if (!s.xhave) begin
                        next_s.xl    = ent;
                        next_s.xhave = 1'b1;
                    end else begin
                        next_s.mv_valid    = 1'b1;
                        next_s.mv_x        = 16'(s.ox + {{8{s.xl[7]}}, s.xl});
                        next_s.mv_y        = 16'(s.oy + {{8{ent[7]}}, ent});
                        next_s.mv_pen_down = !(s.first || s.lift);
                        next_s.first = 1'b0;
                        next_s.lift  = 1'b0;
                        next_s.xhave = 1'b0;
                    end
                end
            end
            default: begin
                next_s.st = gdb_pkg::ST_IDLE;
            end
        endcase

        // A new command aborts any playback; its buffer state is still intact
        if (cmd_start) begin
            next_s.st        = gdb_pkg::ST_PARSE;
            next_s.n_prm     = 9'h000;
            next_s.have_code = 1'b0;
            next_s.bad       = 1'b0;
            next_s.trunc     = 1'b0;
            next_s.lift_pend = 1'b0;
            next_s.odd       = 1'b0;
        end
        if (init_evt || dflt_evt || alloc_evt) begin
            next_s.len  = '0;
            next_s.used = 16'h0000;
            if (s.st == gdb_pkg::ST_DRAW) begin
                next_s.st = gdb_pkg::ST_IDLE;
            end
        end
        if (alloc_evt) begin
            next_s.cap = alloc_bytes;
        end
        next_s.busy = (next_s.st != gdb_pkg::ST_IDLE);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s     <= '0;
            s.st  <= gdb_pkg::ST_IDLE;
            s.cap <= gdb_pkg::DEF_CAP;
        end else begin
            s <= next_s;
        end
    end

    assign busy        = s.busy;
    assign cmd_done    = s.cmd_done;
    assign err_valid   = s.err_valid;
    assign err_code    = s.err_code;
    assign mv_valid    = s.mv_valid;
    assign mv_x        = s.mv_x;
    assign mv_y        = s.mv_y;
    assign mv_pen_down = s.mv_pen_down;
    assign adv_valid   = s.adv_valid;
    assign adv_x       = s.adv_x;
    assign adv_y       = s.adv_y;
    assign miss_valid  = s.miss_valid;
    assign miss_mode   = s.miss_mode;
    assign used_bytes  = s.used;

    property p_clear_all;
        @(posedge clk) disable iff (!rst_b)
        (s.st == gdb_pkg::ST_PARSE && !prm_valid && cmd_end && !s.have_code
         && !cmd_start) |=> (s.used == 16'h0000 && s.len == '0 && !s.err_valid);
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("full clear failed");

    property p_delete_one;
        @(posedge clk) disable iff (!rst_b)
        (s.st == gdb_pkg::ST_PARSE && !prm_valid && cmd_end && s.have_code && !s.bad
         && s.n_prm == 9'h000 && !cmd_start && !init_evt && !dflt_evt && !alloc_evt)
        |=> (cur_len == 9'h000 && s.used == 16'($past(s.used) - 16'($past(cur_len))));
    endproperty
    a_delete_one: assert property (p_delete_one) else $error("single delete wrong");

    property p_range_err;
        @(posedge clk) disable iff (!rst_b)
        (s.st == gdb_pkg::ST_PARSE && !prm_valid && cmd_end && s.have_code && s.bad
         && !init_evt && !dflt_evt && !alloc_evt)
        |=> (s.err_valid && s.err_code == gdb_pkg::ERR_RANGE && $stable(s.used));
    endproperty
    a_range_err: assert property (p_range_err) else $error("range error not reported");

    property p_odd_err;
        @(posedge clk) disable iff (!rst_b)
        (s.st == gdb_pkg::ST_PARSE && !prm_valid && cmd_end && s.have_code && !s.bad
         && s.n_prm != 9'h000 && s.odd) |=> (s.err_valid && s.err_code == 4'h3);
    endproperty
    a_odd_err: assert property (p_odd_err) else $error("odd count not rejected");

    property p_trunc;
        @(posedge clk) disable iff (!rst_b)
        (s.st == gdb_pkg::ST_PARSE && prm_valid && s.have_code && s.n_prm == 9'h0FF
         && !cmd_start) |=> (s.trunc && s.n_prm == 9'h0FF);
    endproperty
    a_trunc: assert property (p_trunc) else $error("parameter limit not held");

    property p_first_up;
        @(posedge clk) disable iff (!rst_b)
        (s.st == gdb_pkg::ST_DRAW && s.first) |=> (!s.mv_valid || !s.mv_pen_down);
    endproperty
    a_first_up: assert property (p_first_up) else $error("first pair not pen up");

    property p_lift_up;
        @(posedge clk) disable iff (!rst_b)
        (s.st == gdb_pkg::ST_DRAW && s.lift) |=> (!s.mv_valid || !s.mv_pen_down);
    endproperty
    a_lift_up: assert property (p_lift_up) else $error("pen lift ignored");

    property p_draw_down;
        @(posedge clk) disable iff (!rst_b)
        (s.st == gdb_pkg::ST_DRAW && !s.first && !s.lift && !cmd_start && !init_evt
         && !dflt_evt && !alloc_evt) |=> (!s.mv_valid || s.mv_pen_down);
    endproperty
    a_draw_down: assert property (p_draw_down) else $error("plain pair not pen down");

    property p_advance;
        @(posedge clk) disable iff (!rst_b)
        s.adv_valid |-> (s.adv_x == 16'(s.ox + 16'sh0030) && s.adv_y == s.oy);
    endproperty
    a_advance: assert property (p_advance) else $error("advance not from origin");

    property p_overflow;
        @(posedge clk) disable iff (!rst_b)
        (s.err_valid && s.err_code == gdb_pkg::ERR_OVERFLOW) |-> (cur_len == 9'h000);
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow kept definition");

    property p_init_clear;
        @(posedge clk) disable iff (!rst_b)
        (init_evt || dflt_evt || alloc_evt) |=> (s.used == 16'h0000 && s.len == '0);
    endproperty
    a_init_clear: assert property (p_init_clear) else $error("buffer not emptied");
endmodule

// ==== tb/gdb_host_model.sv ====
// Host model: sends define-glyph commands on the command port
`timescale 1ns/100ps
module gdb_host_model (
    input  wire logic          clk,
    output logic               cmd_start,
    output logic               prm_valid,
    output logic signed [15:0] prm_value,
    output logic               cmd_end
);
    logic signed [15:0] q[$];

    initial begin
        cmd_start = 1'b0;
        prm_valid = 1'b0;
        prm_value = 16'sh0000;
        cmd_end   = 1'b0;
    end

    // Code first, data after, terminator last; gap gives a slow host
    task automatic send(input int gap);
        int i;
        @(posedge clk);
        cmd_start <= 1'b1;
        for (i = 0; i < q.size(); i++) begin
            @(posedge clk);
            cmd_start <= 1'b0;
            prm_valid <= 1'b1;
            prm_value <= q[i];
            repeat (gap) begin
                @(posedge clk);
                prm_valid <= 1'b0;
                // Released data is inverted on every gap cycle, so it toggles around its last value
                prm_value <= ~prm_value;
            end
        end
        @(posedge clk);
        cmd_start <= 1'b0;
        prm_valid <= 1'b0;
        prm_value <= ~prm_value;
        cmd_end   <= 1'b1;
        @(posedge clk);
        cmd_end <= 1'b0;
        q.delete();
    endtask
endmodule

// ==== tb/tb_gdb_glyph_buffer.sv ====
// Testbench for the glyph download buffer
`timescale 1ns/100ps
module tb_gdb_glyph_buffer;
    logic clk, rst_b, init_evt, dflt_evt, alloc_evt, fb_sel_valid, draw_req;
    logic cmd_start, prm_valid, cmd_end, busy, cmd_done, err_valid, mv_valid, mv_pen_down;
    logic adv_valid, miss_valid;
    logic signed [15:0] prm_value, draw_ox, draw_oy, mv_x, mv_y, adv_x, adv_y;
    logic [15:0] alloc_bytes, used_bytes;
    logic [1:0]  fb_sel_mode, miss_mode;
    logic [7:0]  draw_code;
    logic [3:0]  err_code;
    logic signed [15:0] ex_x[$], ex_y[$];
    logic        ex_d[$];
    int          n_errors, samples_checked, cycles;

    // Slot wide enough for a full 255-parameter glyph
    gdb_glyph_buffer #(.SLOT_BYTES(300), .STAGE_DEPTH(255)) gdb_glyph_buffer_i (
        .clk(clk), .rst_b(rst_b), .cmd_start(cmd_start), .prm_valid(prm_valid),
        .prm_value(prm_value), .cmd_end(cmd_end), .init_evt(init_evt), .dflt_evt(dflt_evt),
        .alloc_evt(alloc_evt), .alloc_bytes(alloc_bytes), .fb_sel_valid(fb_sel_valid),
        .fb_sel_mode(fb_sel_mode), .draw_req(draw_req), .draw_code(draw_code),
        .draw_ox(draw_ox), .draw_oy(draw_oy), .busy(busy), .cmd_done(cmd_done),
        .err_valid(err_valid), .err_code(err_code), .mv_valid(mv_valid), .mv_x(mv_x),
        .mv_y(mv_y), .mv_pen_down(mv_pen_down), .adv_valid(adv_valid), .adv_x(adv_x),
        .adv_y(adv_y), .miss_valid(miss_valid), .miss_mode(miss_mode),
        .used_bytes(used_bytes));
    gdb_host_model gdb_host_model_i (.clk(clk), .cmd_start(cmd_start),
        .prm_valid(prm_valid), .prm_value(prm_value), .cmd_end(cmd_end));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic close_out();
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Hang guard: whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Send queued command, then judge completion, error and byte count
    task automatic define(input int gap, input logic ev, input logic [3:0] ec,
                          input logic [15:0] used);
        int k;
        gdb_host_model_i.send(gap);
        for (k = 0; k < 20 && cmd_done !== 1'b1; k++) begin
            #1;
            if (cmd_done !== 1'b1) @(posedge clk);
        end
        chk("cmd_done", 16'h0001, {15'h0000, cmd_done});
        chk("busy_done", 16'h0000, {15'h0000, busy});
        chk("err_valid", {15'h0000, ev}, {15'h0000, err_valid});
        if (ev) chk("err_code", {12'h000, ec}, {12'h000, err_code});
        @(posedge clk);
        #1;
        chk("used_bytes", used, used_bytes);
    endtask

    // Draw a code; hit compares queued moves and the advance, miss the mode
    task automatic draw(input logic [7:0] code, input logic signed [15:0] ox,
                        input logic signed [15:0] oy, input logic hit);
        int k;
        @(posedge clk);
        draw_req  <= 1'b1;
        draw_code <= code;
        draw_ox   <= ox;
        draw_oy   <= oy;
        @(posedge clk);
        draw_req <= 1'b0;
        for (k = 0; k < 600; k++) begin
            #1;
            if (k == 0) chk("busy_draw", {15'h0000, hit}, {15'h0000, busy});
            if (mv_valid === 1'b1) begin
                chk("moves", 16'h0001, {15'h0000, ex_x.size() > 0});
                if (ex_x.size() > 0) begin
                    chk("mv_x", ex_x.pop_front(), mv_x);
                    chk("mv_y", ex_y.pop_front(), mv_y);
                    chk("mv_pen_down", {15'h0000, ex_d.pop_front()}, {15'h0000, mv_pen_down});
                end
            end
            if (adv_valid === 1'b1 || miss_valid === 1'b1) break;
            @(posedge clk);
        end
        chk("hit", {15'h0000, hit}, {15'h0000, adv_valid});
        chk("miss", {15'h0000, ~hit}, {15'h0000, miss_valid});
        chk("left_moves", 16'h0000, 16'(ex_x.size()));
        if (hit) chk("adv_x", ox + gdb_pkg::CELL_W, adv_x);
        if (hit) chk("adv_y", oy, adv_y);
        if (!hit) chk("miss_mode", 16'h0002, {14'h0000, miss_mode});
        ex_x.delete();
        ex_y.delete();
        ex_d.delete();
    endtask

    task automatic mv(input logic signed [15:0] x, input logic signed [15:0] y,
                      input logic d);
        ex_x.push_back(x);
        ex_y.push_back(y);
        ex_d.push_back(d);
    endtask

    task automatic bad(input logic signed [15:0] p[6], input int n);
        int i;
        for (i = 0; i < n; i++) gdb_host_model_i.q.push_back(p[i]);
        define(0, 1'b1, gdb_pkg::ERR_RANGE, 16'h0005);
    endtask

    task automatic pulse_evt(input int k);
        @(posedge clk);
        if (k == 0) init_evt <= 1'b1;
        else if (k == 1) dflt_evt <= 1'b1;
        else alloc_evt <= 1'b1;
        @(posedge clk);
        init_evt  <= 1'b0;
        dflt_evt  <= 1'b0;
        alloc_evt <= 1'b0;
        @(posedge clk);
        #1;
        chk("used_bytes_clear", 16'h0000, used_bytes);
    endtask

    initial begin
        int i;
        logic signed [15:0] P;
        P = gdb_pkg::PEN_LIFT;
        rst_b = 1'b0; init_evt = 1'b0; dflt_evt = 1'b0; alloc_evt = 1'b0;
        alloc_bytes = 16'h0000; fb_sel_valid = 1'b0; fb_sel_mode = 2'h0; draw_req = 1'b0;
        draw_code = 8'h00; draw_ox = 16'sh0000; draw_oy = 16'sh0000;
        n_errors = 0; samples_checked = 0; cycles = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        fb_sel_valid <= 1'b1;
        fb_sel_mode  <= 2'h2;
        @(posedge clk);
        fb_sel_valid <= 1'b0;
        // First pair up, later pairs down, advance from origin
        gdb_host_model_i.q = '{16'sh0041, 16'sh000A, 16'sh0000, 16'sh000A, 16'sh001E};
        define(0, 1'b0, 4'h0, 16'h0005);
        mv(16'sh006E, 16'sh00C8, 1'b0);
        mv(16'sh006E, 16'sh00E6, 1'b1);
        draw(8'h41, 16'sh0064, 16'sh00C8, 1'b1);
        // Pen lift raises the next pair only, slow host
        gdb_host_model_i.q = '{16'sh0042, P, 16'sh0000, 16'sh0000, 16'sh0005, 16'sh0005,
                               P, 16'sh0009, 16'sh0009, 16'sh0007, 16'sh0007};
        define(2, 1'b0, 4'h0, 16'h0010);
        mv(16'sh0000, 16'sh0000, 1'b0);
        mv(16'sh0005, 16'sh0005, 1'b1);
        mv(16'sh0009, 16'sh0009, 1'b0);
        mv(16'sh0007, 16'sh0007, 1'b1);
        draw(8'h42, 16'sh0000, 16'sh0000, 1'b1);
        gdb_host_model_i.q = '{16'sh0041, 16'sh0001, 16'sh0002, 16'sh0003, 16'sh0004};
        define(0, 1'b0, 4'h0, 16'h0010);
        mv(16'sh0001, 16'sh0002, 1'b0);
        mv(16'sh0003, 16'sh0004, 1'b1);
        draw(8'h41, 16'sh0000, 16'sh0000, 1'b1);
        gdb_host_model_i.q = '{16'sh0042};
        define(0, 1'b0, 4'h0, 16'h0005);
        draw(8'h42, 16'sh0000, 16'sh0000, 1'b0);
        // Refused commands leave the buffer as it was
        bad('{16'sh0020, 16'sh0001, 16'sh0001, 16'sh0, 16'sh0, 16'sh0}, 3);
        bad('{16'sh007F, 16'sh0001, 16'sh0001, 16'sh0, 16'sh0, 16'sh0}, 3);
        bad('{16'sh0043, 16'sh0001, 16'sh0001, 16'sh0002, 16'sh0, 16'sh0}, 4);
        bad('{16'sh0043, 16'sh0001, 16'sh0001, P, 16'sh0, 16'sh0}, 4);
        bad('{16'sh0043, 16'sh0001, 16'sh0080, 16'sh0, 16'sh0, 16'sh0}, 3);
        bad('{16'sh0043, P, P, 16'sh0001, 16'sh0001, 16'sh0}, 5);
        // Over-long command keeps first 255 data parameters
        gdb_host_model_i.q = '{16'sh0046, P};
        for (i = 0; i < 256; i++) gdb_host_model_i.q.push_back(16'sh0005);
        define(0, 1'b1, gdb_pkg::ERR_COUNT, 16'h0105);
        gdb_host_model_i.q = '{};
        define(0, 1'b0, 4'h0, 16'h0000);
        draw(8'h41, 16'sh0000, 16'sh0000, 1'b0);
        // Small allocation: 452 overhead plus 8 bytes
        gdb_host_model_i.q = '{16'sh0044, 16'sh0001, 16'sh0001};
        define(0, 1'b0, 4'h0, 16'h0003);
        alloc_bytes <= 16'h01CC;
        pulse_evt(2);
        gdb_host_model_i.q = '{16'sh0044, 16'sh0001, 16'sh0001, 16'sh0002, 16'sh0002};
        define(0, 1'b0, 4'h0, 16'h0005);
        gdb_host_model_i.q = '{16'sh0044, 16'sh0001, 16'sh0001, 16'sh0002, 16'sh0002,
                               16'sh0003, 16'sh0003, 16'sh0004, 16'sh0004};
        define(0, 1'b1, gdb_pkg::ERR_OVERFLOW, 16'h0000);
        draw(8'h44, 16'sh0000, 16'sh0000, 1'b0);
        for (i = 0; i < 2; i++) begin
            gdb_host_model_i.q = '{16'sh0041, 16'sh0001, 16'sh0001};
            define(0, 1'b0, 4'h0, 16'h0003);
            pulse_evt(i);
        end
        close_out();
    end
endmodule
